//--- common/dpxd_pkg.sv
// Purpose: shared constants and types of the dual pointer data-space decoder
// Assumes: 100 MHz core clock, byte-wide special register space
// Notes:   all offsets, field positions and strobe counts live here; reset values except pointers and external select
`default_nettype none
package dpxd_pkg;
    // special register addresses
    localparam logic [7:0]  PBC_ADDR         = 8'ha2;
    localparam logic [7:0]  AUXC_ADDR        = 8'h8e;
    localparam logic [7:0]  PTR_LO_ADDR      = 8'h82;
    localparam logic [7:0]  PTR_HI_ADDR      = 8'h83;
    // pointer_boot_control fields
    localparam int          PBC_SEL_BIT      = 0;
    localparam int          PBC_ZERO_BIT     = 2;
    localparam int          PBC_FLAG_BIT     = 3;
    localparam int          PBC_BOOT_BIT     = 5;
    // aux_control fields
    localparam int          AUXC_EXT_BIT     = 1;
    localparam int          AUXC_SIZE_LSB    = 2;
    localparam int          AUXC_STRETCH_BIT = 5;
    // reset values
    localparam logic        PBC_SEL_RESET    = 1'b0;
    localparam logic        PBC_FLAG_RESET   = 1'b0;
    localparam logic        PBC_BOOT_RESET   = 1'b0;
    localparam logic [2:0]  SIZE_RESET       = 3'h2;
    localparam logic        STRETCH_RESET    = 1'b0;
    // address map
    localparam logic [7:0]  LOWER_RAM_TOP    = 8'h7f;
    localparam logic [15:0] BOOT_BASE        = 16'hf800;
    localparam int          EXPANDED_RAM_DEPTH       = 1792;
    localparam int          EXPANDED_RAM_AW          = 11;
    localparam int          IDATA_DEPTH      = 256;
    localparam int          IDATA_AW         = 8;
    localparam logic [15:0] XSIZE_256        = 16'h0100;
    localparam logic [15:0] XSIZE_512        = 16'h0200;
    localparam logic [15:0] XSIZE_768        = 16'h0300;
    localparam logic [15:0] XSIZE_1024       = 16'h0400;
    localparam logic [15:0] XSIZE_1792       = 16'h0700;
    // strobe timing
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          STROBE_SHORT_NS  = 60;
    localparam int          STROBE_LONG_NS   = 300;
    localparam logic [4:0]  STROBE_SHORT_CYC =
        5'((STROBE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0]  STROBE_LONG_CYC  =
        5'((STROBE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_EXPANDED_RAM,
        BUS_ADDR,
        BUS_STROBE
    } dpxd_bus_state_t;

    // accessible expanded ram size; unlisted codes fall back to the smallest
    function automatic logic [15:0] dpxd_expanded_ram_size(input logic [2:0] code);
        case (code)
            3'h0:    dpxd_expanded_ram_size = XSIZE_256;
            3'h1:    dpxd_expanded_ram_size = XSIZE_512;
            3'h2:    dpxd_expanded_ram_size = XSIZE_768;
            3'h3:    dpxd_expanded_ram_size = XSIZE_1024;
            3'h4:    dpxd_expanded_ram_size = XSIZE_1792;
            default: dpxd_expanded_ram_size = XSIZE_256;
        endcase
    endfunction : dpxd_expanded_ram_size
endpackage : dpxd_pkg
`default_nettype wire

//--- src/dpxd_mem.sv
// Purpose: single-port byte memory with registered read data
// Assumes: one access per cycle; on a write cycle the read data register still updates, with the old contents
// Notes:   no reset on the array; read data register resets to zero
`default_nettype none
module dpxd_mem #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          arst_n,
    // access port
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output var  logic [7:0]    rdata
);
    logic [7:0] mem_q [DEPTH];

    // array write
    always_ff @(posedge clock) begin
        if (we) begin
            mem_q[addr] <= wdata;
        end
    end

    // registered read, every cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= mem_q[addr];
        end
    end
endmodule : dpxd_mem
`default_nettype wire

//--- src/dpxd_strobe.sv
// Purpose: length counter for the external read and write strobes
// Assumes: start is a one-cycle pulse and is not repeated while active
// Notes:   length is latched at start so a mid-cycle change cannot shorten a pulse
`default_nettype none
module dpxd_strobe
    import dpxd_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic arst_n,
    // control
    input  wire logic start,
    input  wire logic stretch,
    // status
    output var  logic active,
    output var  logic last
);
    logic [4:0] cnt_r;
    logic [4:0] len_r;
    logic       busy_r;

    assign active = busy_r;
    assign last   = busy_r && (cnt_r == len_r - 5'h01);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busy_r <= 1'b0;
            cnt_r  <= 5'h00;
            len_r  <= STROBE_SHORT_CYC;
        end else if (start) begin
            busy_r <= 1'b1;
            cnt_r  <= 5'h00;
            len_r  <= stretch ? STROBE_LONG_CYC : STROBE_SHORT_CYC;
        end else if (last) begin
            busy_r <= 1'b0;
        end else if (busy_r) begin
            cnt_r  <= cnt_r + 5'h01;
        end
    end
endmodule : dpxd_strobe
`default_nettype wire

//--- src/dpxd_top.sv
// Summary of operation
// - two independent 16-bit data pointers
// - select bit 0 chooses pointer one
// - bit 5 maps boot ROM at F800h up
// - bit 3 is plain software flag
// - bit 2 reads zero, increment toggles select
// - control register at 0A2h, byte access only
// - on-chip expanded ram up to 1792 bytes
// - addresses 00h-7Fh select lower ram
// - direct 80h-FFh reaches special registers
// - indirect above 7Fh reaches upper ram
// - expanded ram at bottom when selected
// - size field limits expanded ram reach
// - expanded ram access leaves pins idle
// - index or pointer moves hit expanded ram
// - pointer moves at or above size use bus
// - above 0FFh only via pointer
// - index bus move drives 8-bit address
// - pointer bus move drives high, low bytes
// - active-low write and read strobes
// - stack stays in internal data ram
// - stretch makes strobes 30 not 6
// - size codes 256,512,768,1024,1792 bytes
// - external select loaded from security strap
//
// Purpose: data-space decode, dual pointers and external move bus of the core
// Assumes: core issues one internal and one external request at a time
// Notes:   reserved control bits read zero so an increment never carries past them
`default_nettype none
module dpxd_top
    import dpxd_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // security strap
    input  wire logic        hsb_external_data_select,
    // internal data access
    input  wire logic        idata_req,
    input  wire logic        idata_indirect,
    input  wire logic        idata_stack,
    input  wire logic        idata_we,
    input  wire logic [7:0]  idata_addr,
    input  wire logic [7:0]  idata_wdata,
    output logic      [7:0]  idata_rdata,
    output logic             idata_valid,
    output logic             idata_sfr_hit,
    // pointer operations
    input  wire logic        ptr_load,
    input  wire logic [15:0] ptr_load_value,
    input  wire logic        ptr_inc,
    output logic      [15:0] ptr_value,
    // external move
    input  wire logic        xmov_req,
    input  wire logic        xmov_use_ptr,
    input  wire logic        xmov_we,
    input  wire logic [7:0]  xmov_index,
    input  wire logic [7:0]  xmov_wdata,
    output logic      [7:0]  xmov_rdata,
    output logic             xmov_done,
    output logic             xmov_busy,
    // program fetch map
    input  wire logic [15:0] prog_addr,
    output logic             boot_rom_sel,
    // multiplexed bus pins
    input  wire logic [7:0]  port0_in,
    output logic      [7:0]  port0_out,
    output logic             port0_oe,
    output logic      [7:0]  port2_out,
    output logic             port2_oe,
    output logic             addr_latch,
    output logic             rd_n,
    output logic             wr_n
);
    // control state
    logic [15:0]     ptr0_r, ptr0_nxt, ptr1_r, ptr1_nxt, ptr_act_r;
    logic            sel_r, sel_nxt, flag_r, boot_en_r;
    logic            ext_sel_r, strap_pend_r, stretch_r;
    logic [2:0]      size_r;
    // internal data pipeline
    logic [7:0]      sfr_rd_r, idata_rdata_r;
    logic            idata_pend_r, idata_sfr_r, idata_valid_r;
    logic            boot_sel_r;
    // external bus
    dpxd_bus_state_t st_r, st_nxt;
    logic [15:0]     xaddr_r, xaddr_nxt;
    logic [7:0]      xdata_r, xdata_nxt, xrdata_r, xrdata_nxt;
    logic            xwe_r, xwe_nxt, xptr_r, xptr_nxt;
    logic            done_r, done_nxt, busy_r, busy_nxt;
    logic [7:0]      p0_r, p0_nxt, p2_r, p2_nxt;
    logic            p0oe_r, p0oe_nxt, p2oe_r, p2oe_nxt, ale_r, ale_nxt;
    logic            rdn_r, rdn_nxt, wrn_r, wrn_nxt;

    // decode of internal data requests
    wire        ind_w      = idata_indirect | idata_stack;           // stack is always indirect
    wire        hi_w       = idata_addr > LOWER_RAM_TOP;
    wire        sfr_acc_w  = idata_req && !ind_w && hi_w;
    wire        sfr_wr_w   = sfr_acc_w && idata_we;
    wire        imem_we_w  = idata_req && idata_we && (ind_w || !hi_w);
    wire        wr_pbc_w   = sfr_wr_w && (idata_addr == PBC_ADDR);
    wire        wr_aux_w   = sfr_wr_w && (idata_addr == AUXC_ADDR);
    wire        wr_plo_w   = sfr_wr_w && (idata_addr == PTR_LO_ADDR);
    wire        wr_phi_w   = sfr_wr_w && (idata_addr == PTR_HI_ADDR);
    wire [7:0]  imem_rd_w;
    wire [7:0]  xmem_rd_w;

    wire [7:0]  pbc_img_w  = {2'b00, boot_en_r, 1'b0, flag_r, 1'b0, 1'b0, sel_r};
    wire [7:0]  aux_img_w  = {2'b00, stretch_r, size_r, ext_sel_r, 1'b0};
    wire [7:0]  sfr_rd_w   = (idata_addr == PBC_ADDR)    ? pbc_img_w :
                             (idata_addr == AUXC_ADDR)   ? aux_img_w :
                             (idata_addr == PTR_LO_ADDR) ? ptr_act_r[7:0] :
                             (idata_addr == PTR_HI_ADDR) ? ptr_act_r[15:8] : 8'h00;

    wire [15:0] act_w      = sel_r ? ptr1_r : ptr0_r;
    wire [15:0] act_nxt_w  = ptr_load ? ptr_load_value :
                             ptr_inc  ? act_w + 16'h0001 :
                             wr_plo_w ? {act_w[15:8], idata_wdata} :
                             wr_phi_w ? {idata_wdata, act_w[7:0]} : act_w;
    assign ptr0_nxt = sel_r ? ptr0_r : act_nxt_w;
    assign ptr1_nxt = sel_r ? act_nxt_w : ptr1_r;
    assign sel_nxt  = wr_pbc_w ? idata_wdata[PBC_SEL_BIT] : sel_r;

    // expanded ram hit; index moves never exceed 255
    wire [15:0] xsize_w    = dpxd_expanded_ram_size(size_r);
    wire        xhit_w     = !ext_sel_r && (!xmov_use_ptr || (act_w < xsize_w));
    wire        xstart_w   = (st_r == BUS_IDLE) && xmov_req;
    wire        xmem_we_w  = xstart_w && xhit_w && xmov_we;
    wire [10:0] xmem_a_w   = xmov_use_ptr ? act_w[10:0] : {3'b000, xmov_index};
    wire        stb_start_w = (st_r == BUS_ADDR);
    wire        stb_last_w;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ptr0_r    <= 16'h0000;
            ptr1_r    <= 16'h0000;
            ptr_act_r <= 16'h0000;
            sel_r     <= PBC_SEL_RESET;
            flag_r    <= PBC_FLAG_RESET;
            boot_en_r <= PBC_BOOT_RESET;
            stretch_r <= STRETCH_RESET;
            size_r    <= SIZE_RESET;
        end else begin
            ptr0_r    <= ptr0_nxt;
            ptr1_r    <= ptr1_nxt;
            ptr_act_r <= sel_nxt ? ptr1_nxt : ptr0_nxt;
            sel_r     <= sel_nxt;
            if (wr_pbc_w) begin
                flag_r    <= idata_wdata[PBC_FLAG_BIT];
                boot_en_r <= idata_wdata[PBC_BOOT_BIT];
            end
            if (wr_aux_w) begin
                stretch_r <= idata_wdata[AUXC_STRETCH_BIT];
                size_r    <= idata_wdata[AUXC_SIZE_LSB +: 3];
            end
        end
    end

    // strap caught on the first edge after reset release
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            strap_pend_r <= 1'b1;
            ext_sel_r    <= 1'b0;
        end else if (strap_pend_r) begin
            strap_pend_r <= 1'b0;
            ext_sel_r    <= hsb_external_data_select;
        end else if (wr_aux_w) begin
            ext_sel_r    <= idata_wdata[AUXC_EXT_BIT];
        end
    end

    // internal data answer two cycles after the request
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            idata_pend_r  <= 1'b0;
            idata_sfr_r   <= 1'b0;
            sfr_rd_r      <= 8'h00;
            idata_rdata_r <= 8'h00;
            idata_valid_r <= 1'b0;
        end else begin
            idata_pend_r  <= idata_req;
            idata_sfr_r   <= sfr_acc_w;
            sfr_rd_r      <= sfr_rd_w;
            idata_valid_r <= idata_pend_r;
            if (idata_pend_r) begin
                idata_rdata_r <= idata_sfr_r ? sfr_rd_r : imem_rd_w;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            boot_sel_r <= 1'b0;
        end else begin
            boot_sel_r <= boot_en_r && (prog_addr >= BOOT_BASE);
        end
    end

    // external move sequencer
    always_comb begin
        st_nxt     = st_r;
        xaddr_nxt  = xaddr_r;
        xdata_nxt  = xdata_r;
        xwe_nxt    = xwe_r;
        xptr_nxt   = xptr_r;
        xrdata_nxt = xrdata_r;
        done_nxt   = 1'b0;
        busy_nxt   = busy_r;
        p0_nxt     = p0_r;
        p0oe_nxt   = p0oe_r;
        p2_nxt     = p2_r;
        p2oe_nxt   = p2oe_r;
        ale_nxt    = 1'b0;
        rdn_nxt    = rdn_r;
        wrn_nxt    = wrn_r;
        case (st_r)
            BUS_IDLE: begin
                if (xmov_req) begin
                    xaddr_nxt = xmov_use_ptr ? act_w : {8'h00, xmov_index};
                    xdata_nxt = xmov_wdata;
                    xwe_nxt   = xmov_we;
                    xptr_nxt  = xmov_use_ptr;
                    busy_nxt  = 1'b1;
                    if (xhit_w) begin
                        st_nxt = BUS_EXPANDED_RAM;
                    end else begin
                        st_nxt   = BUS_ADDR;
                        ale_nxt  = 1'b1;
                        p0_nxt   = xaddr_nxt[7:0];
                        p0oe_nxt = 1'b1;
                        p2_nxt   = xaddr_nxt[15:8];
                        p2oe_nxt = xmov_use_ptr;
                    end
                end
            end
            BUS_EXPANDED_RAM: begin
                if (!xwe_r) begin
                    xrdata_nxt = xmem_rd_w;
                end
                done_nxt = 1'b1;
                busy_nxt = 1'b0;
                st_nxt   = BUS_IDLE;
            end
            BUS_ADDR: begin
                p0_nxt   = xdata_r;
                p0oe_nxt = xwe_r;
                wrn_nxt  = !xwe_r;
                rdn_nxt  = xwe_r;
                st_nxt   = BUS_STROBE;
            end
            BUS_STROBE: begin
                if (stb_last_w) begin
                    // read data sampled on the closing edge of the strobe
                    if (!xwe_r) begin
                        xrdata_nxt = port0_in;
                    end
                    rdn_nxt  = 1'b1;
                    wrn_nxt  = 1'b1;
                    p0oe_nxt = 1'b0;
                    p2oe_nxt = 1'b0;
                    done_nxt = 1'b1;
                    busy_nxt = 1'b0;
                    st_nxt   = BUS_IDLE;
                end
            end
            default: begin
                st_nxt = BUS_IDLE;
            end
        endcase
    end

    // external move state registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_r     <= BUS_IDLE;
            xaddr_r  <= 16'h0000;
            xdata_r  <= 8'h00;
            xwe_r    <= 1'b0;
            xptr_r   <= 1'b0;
            xrdata_r <= 8'h00;
            done_r   <= 1'b0;
            busy_r   <= 1'b0;
            p0_r     <= 8'h00;
            p0oe_r   <= 1'b0;
            p2_r     <= 8'h00;
            p2oe_r   <= 1'b0;
            ale_r    <= 1'b0;
            rdn_r    <= 1'b1;
            wrn_r    <= 1'b1;
        end else begin
            st_r     <= st_nxt;
            xaddr_r  <= xaddr_nxt;
            xdata_r  <= xdata_nxt;
            xwe_r    <= xwe_nxt;
            xptr_r   <= xptr_nxt;
            xrdata_r <= xrdata_nxt;
            done_r   <= done_nxt;
            busy_r   <= busy_nxt;
            p0_r     <= p0_nxt;
            p0oe_r   <= p0oe_nxt;
            p2_r     <= p2_nxt;
            p2oe_r   <= p2oe_nxt;
            ale_r    <= ale_nxt;
            rdn_r    <= rdn_nxt;
            wrn_r    <= wrn_nxt;
        end
    end

    dpxd_mem #(.DEPTH(IDATA_DEPTH), .AW(IDATA_AW)) u_idata (
        .clock (clock),
        .arst_n(arst_n),
        .we    (imem_we_w),
        .addr  (idata_addr),
        .wdata (idata_wdata),
        .rdata (imem_rd_w)
    );

    dpxd_mem #(.DEPTH(EXPANDED_RAM_DEPTH), .AW(EXPANDED_RAM_AW)) u_expanded_ram (
        .clock (clock),
        .arst_n(arst_n),
        .we    (xmem_we_w),
        .addr  (xmem_a_w),
        .wdata (xmov_wdata),
        .rdata (xmem_rd_w)
    );

    // strobe length timer
    dpxd_strobe u_strobe (
        .clock  (clock),
        .arst_n (arst_n),
        .start  (stb_start_w),
        .stretch(stretch_r),
        .active (),
        .last   (stb_last_w)
    );

    // outputs straight from flops
    assign idata_rdata   = idata_rdata_r;
    assign idata_valid   = idata_valid_r;
    assign idata_sfr_hit = idata_sfr_r;
    assign ptr_value     = ptr_act_r;
    assign xmov_rdata    = xrdata_r;
    assign xmov_done     = done_r;
    assign xmov_busy     = busy_r;
    assign boot_rom_sel  = boot_sel_r;
    assign port0_out     = p0_r;
    assign port0_oe      = p0oe_r;
    assign port2_out     = p2_r;
    assign port2_oe      = p2oe_r;
    assign addr_latch    = ale_r;
    assign rd_n          = rdn_r;
    assign wr_n          = wrn_r;

    // assertion helpers: strobe low-time counter
    wire        stb_low_w = !rdn_r || !wrn_r;
    logic [5:0] low_cnt_r;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt_r <= 6'h00;
        end else begin
            low_cnt_r <= stb_low_w ? low_cnt_r + 6'h01 : 6'h00;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    AST_PTR_LOAD: assert property (ptr_load && !sel_r |=> ptr0_r == $past(ptr_load_value))
        else $error("load missed pointer zero");
    AST_PTR_OTHER: assert property ((ptr_load || ptr_inc) && sel_r |=> $stable(ptr0_r))
        else $error("unselected pointer changed");
    AST_BOOT_MAP: assert property (boot_en_r && prog_addr >= BOOT_BASE |=> boot_rom_sel)
        else $error("boot window not selected");
    AST_PBC_ZERO: assert property (idata_req && !ind_w && idata_addr == PBC_ADDR && !idata_we
                                   |-> ##2 idata_valid && idata_rdata[PBC_ZERO_BIT] == 1'b0)
        else $error("control bit 2 read nonzero");
    AST_LOWER_RAM: assert property (idata_req && idata_we && !hi_w |-> imem_we_w)
        else $error("lower ram write lost");
    AST_DIRECT_SFR: assert property (idata_req && !ind_w && hi_w |-> !imem_we_w ##1 idata_sfr_hit)
        else $error("direct access reached upper ram");
    AST_UPPER_RAM: assert property (idata_req && ind_w && hi_w && idata_we |-> imem_we_w && !sfr_wr_w)
        else $error("indirect access reached special registers");
    AST_EXPANDED_RAM_PINS: assert property (xstart_w && xhit_w
                                    |=> (rd_n && wr_n && !port0_oe && !port2_oe && !addr_latch) [*2])
        else $error("expanded ram access drove pins");
    AST_BUS_FALL: assert property (xstart_w && !xhit_w |=> addr_latch ##1 (rd_n != wr_n))
        else $error("bus cycle did not start");
    AST_IDX_PAGE: assert property (st_r != BUS_IDLE && !xptr_r |-> !port2_oe)
        else $error("index move drove port 2");
    AST_PTR_HIGH: assert property (st_r == BUS_STROBE && xptr_r |-> port2_oe && port2_out == xaddr_r[15:8])
        else $error("pointer high byte missing");
    AST_STB_SHORT: assert property ($rose(stb_low_w) && !stretch_r |-> stb_low_w [*6] ##1 !stb_low_w)
        else $error("short strobe length wrong");
    AST_STB_LONG: assert property ($fell(stb_low_w) && $past(stretch_r) |-> low_cnt_r == 6'h1e)
        else $error("stretched strobe length wrong");

    COV_EXPANDED_RAM_READ: cover property (xstart_w && xhit_w && !xmov_we ##2 xmov_done);
    COV_BUS_LONG: cover property ($fell(stb_low_w) && low_cnt_r == 6'h1e);
    COV_PBC_TOGGLE: cover property (wr_pbc_w ##1 sel_r);
endmodule : dpxd_top
`default_nettype wire

//--- bench/dpxd_ext_mem.sv
// Purpose: byte memory standing on the multiplexed external bus
// Assumes: address is latched while addr_latch is high
// Notes:   released data line shows the inverse of its last value
`default_nettype none
module dpxd_ext_mem (
    // bus pins
    input  wire logic       clock,
    input  wire logic [7:0] port0_out,
    input  wire logic       port0_oe,
    input  wire logic [7:0] port2_out,
    input  wire logic       port2_oe,
    input  wire logic       addr_latch,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    output var  logic [7:0] port0_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  mem [65536];
    logic [15:0] addr_r;
    // undriven high byte reads as zero, so index moves land in page 0
    always @(posedge clock) begin
        if (addr_latch) addr_r <= {port2_oe ? port2_out : 8'h00, port0_out};
        if (!wr_n && port0_oe) mem[addr_r] <= port0_out;
        port0_in <= !rd_n ? mem[addr_r] : ~port0_in;
    end
endmodule : dpxd_ext_mem
`default_nettype wire

//--- bench/test_dual_pointer_expanded_ram_data_decoder.sv
// Purpose: self-checking bench of the data-space decoder
// Assumes: external memory model on the bus pins
// Notes:   strobe length measured on the pins
`default_nettype none
module test_dual_pointer_expanded_ram_data_decoder;
    import dpxd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0, arst_n = 1'b0, hsb_external_data_select = 1'b0, idata_req = 1'b0, idata_indirect = 1'b0;
    logic        idata_stack = 1'b0, idata_we = 1'b0, ptr_load = 1'b0, ptr_inc = 1'b0, xmov_req = 1'b0;
    logic        xmov_use_ptr = 1'b0, xmov_we = 1'b0, idata_valid, idata_sfr_hit, xmov_done, xmov_busy;
    logic        boot_rom_sel, port0_oe, port2_oe, addr_latch, rd_n, wr_n, h, v, bz;
    logic [7:0]  idata_addr = 8'h00, idata_wdata = 8'h00, xmov_index = 8'h00, xmov_wdata = 8'h00;
    logic [7:0]  idata_rdata, xmov_rdata, port0_in, port0_out, port2_out, q;
    logic [15:0] ptr_load_value = 16'h0000, prog_addr = 16'h0000, ptr_value;
    logic [8:0]  p2;
    int          err_total = 0, checks = 0, cyc = 0, lat_n = 0, lo = 0, lo_len = 0;
    dpxd_top dut (.*);
    dpxd_ext_mem mem_model (.*);
    always #5 clock = ~clock;
    // bus watch; the cycle ceiling covers the stretched moves with margin
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (addr_latch) lat_n <= lat_n + 1;
        if (addr_latch) p2 <= {port2_oe, port2_out};
        if (!rd_n || !wr_n) lo <= lo + 1;
        else lo <= 0;
        if (!rd_n || !wr_n) lo_len <= lo + 1;
        if (cyc == 3000) err_total++;
        if (cyc == 3000) stop_test();
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // internal data access, answer one cycle after the taking edge
    task automatic id(input logic ind, input logic stk, input logic we, input logic [7:0] a, input logic [7:0] d);
        {idata_req, idata_indirect, idata_stack, idata_we, idata_addr, idata_wdata} <= {1'b1, ind, stk, we, a, d};
        @(posedge clock);
        idata_req <= 1'b0;
        #1 h = idata_sfr_hit;
        @(posedge clock);
        #1 v = idata_valid;
        @(posedge clock);
        #1 q = idata_rdata;
    endtask : id
    task automatic pop(input logic ld, input logic [15:0] v);
        {ptr_load, ptr_inc, ptr_load_value} <= {ld, !ld, v};
        @(posedge clock);
        {ptr_load, ptr_inc} <= 2'h0;
        #1;
    endtask : pop
    // external move; hang is cut by the cycle ceiling
    task automatic xm(input logic up, input logic we, input logic [7:0] i, input logic [7:0] d);
        {xmov_req, xmov_use_ptr, xmov_we, xmov_index, xmov_wdata} <= {1'b1, up, we, i, d};
        @(posedge clock);
        xmov_req <= 1'b0;
        #1 bz = xmov_busy;
        while (xmov_done !== 1'b1) begin
            @(posedge clock);
            #1;
        end
        q = xmov_rdata;
    endtask : xm
    task automatic stop_test();
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    initial begin
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1 id(0, 0, 0, PBC_ADDR, 8'h00);
        chk(q, 8'h00);
        id(0, 0, 0, AUXC_ADDR, 8'h00);
        chk(q, {2'h0, STRETCH_RESET, SIZE_RESET, 2'h0});
        id(0, 0, 1, PBC_ADDR, 8'hff);
        id(0, 0, 0, PBC_ADDR, 8'h00);
        chk(q, 8'h29);
        prog_addr <= BOOT_BASE;
        repeat (2) @(posedge clock);
        #1 chk(boot_rom_sel, 1'b1);
        prog_addr <= BOOT_BASE - 16'h0001;
        repeat (2) @(posedge clock);
        #1 chk(boot_rom_sel, 1'b0);
        id(0, 0, 1, PBC_ADDR, q + 8'h01);
        id(0, 0, 0, PBC_ADDR, 8'h00);
        chk(q, 8'h28);
        pop(1, 16'h1234);
        id(0, 0, 1, PBC_ADDR, 8'h29);
        pop(1, 16'habcd);
        pop(0, 16'h0000);
        chk(ptr_value, 16'habce);
        id(0, 0, 1, PBC_ADDR, 8'h28);
        chk(ptr_value, 16'h1234);
        id(1, 0, 1, 8'h90, 8'h66);
        id(0, 0, 1, 8'h90, 8'h55);
        id(1, 0, 0, 8'h90, 8'h00);
        chk(q, 8'h66);
        chk({v, h}, 2'h2);
        id(0, 0, 0, 8'h90, 8'h00);
        chk(q, 8'h00);
        chk({v, h}, 2'h3);
        id(0, 1, 0, 8'h90, 8'h00);
        chk(q, 8'h66);
        id(0, 0, 1, 8'h10, 8'h3c);
        id(1, 0, 0, 8'h10, 8'h00);
        chk(q, 8'h3c);
        pop(1, 16'h02ff);
        xm(1, 1, 8'h00, 8'h5a);
        chk(bz, 1'b1);
        xm(1, 0, 8'h00, 8'h00);
        chk(q, 8'h5a);
        xm(0, 1, 8'h20, 8'h77);
        pop(1, 16'h0020);
        xm(1, 0, 8'h00, 8'h00);
        chk(q, 8'h77);
        chk(16'(lat_n), 16'h0000);
        pop(1, 16'h0300);
        xm(1, 1, 8'h00, 8'ha5);
        chk(bz, 1'b1);
        chk(16'(lo_len), 16'(STROBE_SHORT_CYC));
        chk(16'(p2), 16'h0103);
        xm(1, 0, 8'h00, 8'h00);
        chk(q, 8'ha5);
        id(0, 0, 1, AUXC_ADDR, 8'h30);
        xm(1, 1, 8'h00, 8'h77);
        xm(1, 0, 8'h00, 8'h00);
        chk(q, 8'h77);
        chk(16'(lat_n), 16'h0002);
        pop(1, 16'h0700);
        xm(1, 1, 8'h00, 8'h11);
        chk(16'(lo_len), 16'(STROBE_LONG_CYC));
        id(0, 0, 1, AUXC_ADDR, 8'h32);
        xm(0, 1, 8'h44, 8'h3c);
        chk(p2[8], 1'b0);
        xm(0, 0, 8'h44, 8'h00);
        chk(q, 8'h3c);
        // second reset with the strap set: external bus selected at start
        hsb_external_data_select <= 1'b1;
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1 id(0, 0, 0, AUXC_ADDR, 8'h00);
        chk(q, {2'h0, STRETCH_RESET, SIZE_RESET, 2'h2});
        chk(ptr_value, 16'h0000);
        stop_test();
    end
endmodule : test_dual_pointer_expanded_ram_data_decoder
`default_nettype wire
